// File: shared/cscr_pkg.sv
/*
 * Package for the controller status and control register bank: register
 * offsets, field positions, reset values and the bus carrier struct.
 * Assumes a plain strobe register port with 32-bit data on a 100 MHz clock.
 */
package cscr_pkg;
   localparam int unsigned CSCR_AW = 32;
   localparam int unsigned CSCR_DW = 32;

   // Register byte addresses.
   localparam logic [31:0] CSCR_IRQ_STATUS_ADR = 32'h4000_0000;
   localparam logic [31:0] CSCR_IRQ_ENABLE_ADR = 32'h4000_0004;
   localparam logic [31:0] CSCR_MAIN_STATUS_ADR = 32'h4000_0008;
   localparam logic [31:0] CSCR_VERSION_ADR = 32'h4000_000C;
   localparam logic [31:0] CSCR_MAIN_CTRL_ADR = 32'h4000_0010;
   localparam logic [31:0] CSCR_SELF_TEST_ADR = 32'h4000_0014;
   localparam logic [31:0] CSCR_SYNC_CLR_ADR = 32'h4000_0024;
   localparam logic [31:0] CSCR_SYNC_STATUS_ADR = 32'h4000_0028;

   // Field positions.
   localparam int unsigned CSCR_WDOG_BIT = 2;
   localparam int unsigned CSCR_HERR_LO = 3;
   localparam int unsigned CSCR_HERR_HI = 6;
   localparam int unsigned CSCR_HERR_N = 4;
   localparam int unsigned CSCR_EN_LO = 4;
   localparam int unsigned CSCR_EN_HI = 6;
   localparam int unsigned CSCR_PLL_BIT = 0;
   localparam int unsigned CSCR_SUPPLY_BIT = 1;
   localparam int unsigned CSCR_PARKED_BIT = 2;
   localparam int unsigned CSCR_FASTPWR_BIT = 3;
   localparam int unsigned CSCR_NSTAT = 4;
   localparam int unsigned CSCR_WDEN_BIT = 0;
   localparam int unsigned CSCR_PRBS_BIT = 0;
   localparam int unsigned CSCR_SLOWBUS_BIT = 1;
   localparam int unsigned CSCR_LATCH_BIT = 0;
   localparam int unsigned CSCR_SYNC_BIT = 0;
   localparam int unsigned CSCR_BUILD_LO = 0;
   localparam int unsigned CSCR_MAJOR_LO = 12;
   localparam int unsigned CSCR_MINOR_LO = 20;
   localparam int unsigned CSCR_LEVEL_LO = 28;

   // Reset values.
   localparam logic CSCR_WDEN_RST = 1'h1;
   localparam logic [31:0] CSCR_ZERO = 32'h0000_0000;

   // Watchdog timeout.
   localparam longint unsigned CSCR_WDOG_S = 10;
   localparam longint unsigned CSCR_CLK_HZ = 100_000_000;
   localparam longint unsigned CSCR_WDOG_CYC = CSCR_WDOG_S * CSCR_CLK_HZ;

   typedef struct packed {
      logic [CSCR_AW-1:0] addr;
      logic [CSCR_DW-1:0] wdata;
      logic wr;
      logic rd;
   } cscr_bus_s;
endpackage

// File: logic/cscr_regs.sv
/*
 * Status and control register bank of the micromirror-array controller:
 * interrupt status and enables, main status, version, watchdog, self-test
 * triggers and the sticky sync-error latch.
 * Assumes a one-clock strobe bus master and asynchronous status inputs.
 */
`timescale 1ns/10ps
// How it works
// - Enables 4..6 gate channel 1..3 hard-error status onto the interrupt; reset zero.
// - Main status is read-only; only hardware drives its bits.
// - Main status bit 0 shows PLL lock; resets to zero.
// - Main status bit 1 shows the array supply power-good.
// - Main status bit 2 shows the array parked state.
// - Main status bit 3 shows fast interface power on.
// - Version holds build 11:0, major 19:12, minor 27:20, read-only.
// - Version bits 31:28 are build level, read-only, zero by default.
// - Control bit 0 enables watchdog; resets to one.
// - Writing one to self-test bit 0 starts the link integrity test.
// - Writing one to self-test bit 1 starts the slow bus test.
// - Self-test bits self-clear and always read zero.
// - Latch reset high holds sync error clear; low arms capture.
// - A sync error sets the sticky sync-error flag.
// - Only the latch reset clears the sync-error flag.
// - Latch reset is bit 0, resets zero, upper bits unused.
// - Status bits 3..6 latch channel 0..3 hard errors; write one clears.
// - Enabled watchdog flags bit 2 after 10 s without block reset.
module cscr_regs
   import cscr_pkg::*;
#(
   parameter logic [11:0] BUILD_NUMBER = 12'h001,  // Arbitrary value.
   parameter logic [7:0] MAJOR_VERSION = 8'h01,    // Arbitrary value.
   parameter logic [7:0] MINOR_VERSION = 8'h00,    // Arbitrary value.
   parameter logic [3:0] BUILD_LEVEL = 4'h0,
   parameter longint unsigned WDOG_CYCLES = cscr_pkg::CSCR_WDOG_CYC
) (
   input wire logic CLK,                                    // 100 MHz clock
   input wire logic RSTN,                                   // Sync reset, low
   input wire cscr_pkg::cscr_bus_s BUS,                     // Register requests
   output logic [cscr_pkg::CSCR_DW-1:0] RDATA,              // Read data
   input wire logic [cscr_pkg::CSCR_HERR_N-1:0] HARD_ERR,   // Channel hard errors
   input wire logic PLL_LOCK,                               // PLL locked
   input wire logic ARRAY_SUPPLY_GOOD,                      // Array supply good
   input wire logic ARRAY_PARKED,                           // Array parked
   input wire logic FAST_IF_POWER_ON,                       // Fast interface power
   input wire logic ARRAY_BLOCK_RESET,                      // Block reset event
   input wire logic SYNC_ERR,                               // Interface sync error
   output logic IRQ,                                        // Interrupt, high
   output logic WATCHDOG_EN,                                // Watchdog enabled
   output logic LINK_INTEGRITY_TEST_GO,                     // One-cycle start
   output logic SLOW_BUS_TEST_GO,                           // One-cycle start
   output logic SYNC_ERR_LATCH_RESET                        // Latch clear level
);
   import cscr_pkg::*;

   localparam int unsigned WCW = $clog2(WDOG_CYCLES + 1);
   localparam int unsigned NSYNC = CSCR_HERR_N + CSCR_NSTAT + 2;

   // Elaboration refuses a watchdog span too short for the terminal compare.
   if (WDOG_CYCLES < 2) begin : g_wdog_check
      $error("WDOG_CYCLES must be at least 2");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers.

   logic [NSYNC-1:0] meta_r;
   logic [NSYNC-1:0] sync_r;
   logic [NSYNC-1:0] raw_in;
   logic [CSCR_HERR_N-1:0] herr_s;
   logic [CSCR_NSTAT-1:0] stat_s;
   logic blkrst_s;
   logic syncerr_s;

   assign raw_in = {SYNC_ERR, ARRAY_BLOCK_RESET, FAST_IF_POWER_ON, ARRAY_PARKED,
                    ARRAY_SUPPLY_GOOD, PLL_LOCK, HARD_ERR};
   assign herr_s = sync_r[CSCR_HERR_N-1:0];
   assign stat_s = sync_r[CSCR_HERR_N +: CSCR_NSTAT];
   assign blkrst_s = sync_r[NSYNC-2];
   assign syncerr_s = sync_r[NSYNC-1];

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= raw_in;
         sync_r <= meta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write decode.

   function automatic logic hit(input cscr_bus_s b, input logic [31:0] adr);
      hit = b.addr == adr;
   endfunction

   logic wr_irq_st;
   logic wr_irq_en;
   logic wr_ctrl;
   logic wr_test;
   logic wr_clr;

   assign wr_irq_st = BUS.wr && hit(BUS, CSCR_IRQ_STATUS_ADR);
   assign wr_irq_en = BUS.wr && hit(BUS, CSCR_IRQ_ENABLE_ADR);
   assign wr_ctrl = BUS.wr && hit(BUS, CSCR_MAIN_CTRL_ADR);
   assign wr_test = BUS.wr && hit(BUS, CSCR_SELF_TEST_ADR);
   assign wr_clr = BUS.wr && hit(BUS, CSCR_SYNC_CLR_ADR);

   ////////////////////////////////////////////////////////////////////////////
   // Control registers.

   logic [CSCR_EN_HI:CSCR_WDOG_BIT] irq_en_r;
   logic wden_r;
   logic latch_rst_r;

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         irq_en_r <= '0;
      end else if (wr_irq_en) begin
         irq_en_r <= BUS.wdata[CSCR_EN_HI:CSCR_WDOG_BIT];
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         wden_r <= CSCR_WDEN_RST;
      end else if (wr_ctrl) begin
         wden_r <= BUS.wdata[CSCR_WDEN_BIT];
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         latch_rst_r <= 1'h0;
      end else if (wr_clr) begin
         latch_rst_r <= BUS.wdata[CSCR_LATCH_BIT];
      end
   end

   // Triggers are pulses; no storage so a read can never see them.
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         LINK_INTEGRITY_TEST_GO <= 1'h0;
         SLOW_BUS_TEST_GO <= 1'h0;
      end else begin
         LINK_INTEGRITY_TEST_GO <= wr_test && BUS.wdata[CSCR_PRBS_BIT];
         SLOW_BUS_TEST_GO <= wr_test && BUS.wdata[CSCR_SLOWBUS_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog and interrupt status.

   logic [WCW-1:0] wdog_cnt_r;
   logic wdog_hit;
   logic [CSCR_HERR_HI:CSCR_WDOG_BIT] irq_st_r;
   logic [CSCR_HERR_HI:CSCR_WDOG_BIT] irq_set;

   assign wdog_hit = wden_r && (wdog_cnt_r == WCW'(WDOG_CYCLES - 1));

   // Restarts on each block reset, and when disabled so re-enabling starts fresh.
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         wdog_cnt_r <= '0;
      end else if (!wden_r || blkrst_s || wdog_hit) begin
         wdog_cnt_r <= '0;
      end else begin
         wdog_cnt_r <= wdog_cnt_r + WCW'(1);
      end
   end

   assign irq_set = {herr_s, wdog_hit};

   // A new event in the clearing cycle wins over the clear.
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         irq_st_r <= '0;
      end else begin
         irq_st_r <= irq_set |
            (irq_st_r & ~(wr_irq_st ? BUS.wdata[CSCR_HERR_HI:CSCR_WDOG_BIT] : '0));
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         IRQ <= 1'h0;
      end else begin
         IRQ <= |(irq_st_r & irq_en_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main status and sync-error latch.

   logic [CSCR_NSTAT-1:0] main_st_r;
   logic sync_flag_r;

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         main_st_r <= '0;
      end else begin
         main_st_r <= stat_s;
      end
   end

   // The clear is a level, so an error during it stays lost by design.
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         sync_flag_r <= 1'h0;
      end else if (latch_rst_r) begin
         sync_flag_r <= 1'h0;
      end else if (syncerr_s) begin
         sync_flag_r <= 1'h1;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         WATCHDOG_EN <= CSCR_WDEN_RST;
         SYNC_ERR_LATCH_RESET <= 1'h0;
      end else begin
         WATCHDOG_EN <= wr_ctrl ? BUS.wdata[CSCR_WDEN_BIT] : wden_r;
         SYNC_ERR_LATCH_RESET <= wr_clr ? BUS.wdata[CSCR_LATCH_BIT] : latch_rst_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port; unmapped addresses read zero.

   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = CSCR_ZERO;
      unique case (BUS.addr)
         CSCR_IRQ_STATUS_ADR: rd_mux[CSCR_HERR_HI:CSCR_WDOG_BIT] = irq_st_r;
         CSCR_IRQ_ENABLE_ADR: rd_mux[CSCR_EN_HI:CSCR_WDOG_BIT] = irq_en_r;
         CSCR_MAIN_STATUS_ADR: rd_mux[CSCR_NSTAT-1:0] = main_st_r;
         CSCR_VERSION_ADR: rd_mux = {BUILD_LEVEL, MINOR_VERSION, MAJOR_VERSION,
                                     BUILD_NUMBER};
         CSCR_MAIN_CTRL_ADR: rd_mux[CSCR_WDEN_BIT] = wden_r;
         CSCR_SELF_TEST_ADR: rd_mux = CSCR_ZERO;
         CSCR_SYNC_CLR_ADR: rd_mux[CSCR_LATCH_BIT] = latch_rst_r;
         CSCR_SYNC_STATUS_ADR: rd_mux[CSCR_SYNC_BIT] = sync_flag_r;
         default: rd_mux = CSCR_ZERO;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         RDATA <= '0;
      end else if (BUS.rd) begin
         RDATA <= rd_mux;
      end else begin
         RDATA <= '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   sequence clr_write_s;
      wr_clr && BUS.wdata[CSCR_LATCH_BIT];
   endsequence

   sequence hold_clear_s;
      !sync_flag_r [*2];
   endsequence

   sequence release_s;
      wr_clr && !BUS.wdata[CSCR_LATCH_BIT];
   endsequence

   irq_gate_a: assert property (@(posedge CLK) disable iff (!RSTN)
      (|(irq_st_r & irq_en_r)) |=> IRQ)
      else $error("interrupt missed an enabled status bit");
   irq_quiet_a: assert property (@(posedge CLK) disable iff (!RSTN)
      (irq_en_r == '0) |=> !IRQ)
      else $error("interrupt raised with all enables off");
   status_track_a: assert property (@(posedge CLK) disable iff (!RSTN)
      ##1 main_st_r == $past(stat_s))
      else $error("main status does not follow inputs");
   test_pulse_a: assert property (@(posedge CLK) disable iff (!RSTN)
      LINK_INTEGRITY_TEST_GO |=> !LINK_INTEGRITY_TEST_GO || $past(wr_test))
      else $error("self-test start not a pulse");
   test_start_a: assert property (@(posedge CLK) disable iff (!RSTN)
      (wr_test && BUS.wdata[CSCR_SLOWBUS_BIT]) |=> SLOW_BUS_TEST_GO)
      else $error("slow bus test not started");
   sync_hold_a: assert property (@(posedge CLK) disable iff (!RSTN)
      clr_write_s ##1 (latch_rst_r && !wr_clr) |=> hold_clear_s)
      else $error("sync flag not held clear");
   sync_sticky_a: assert property (@(posedge CLK) disable iff (!RSTN)
      (sync_flag_r && !latch_rst_r) |=> sync_flag_r)
      else $error("sync flag lost without clear");
   sync_set_a: assert property (@(posedge CLK) disable iff (!RSTN)
      (syncerr_s && !latch_rst_r) |=> sync_flag_r)
      else $error("sync error not captured");
   herr_set_a: assert property (@(posedge CLK) disable iff (!RSTN)
      herr_s[0] |=> irq_st_r[CSCR_HERR_LO])
      else $error("hard error not latched");
   wdog_fire_a: assert property (@(posedge CLK) disable iff (!RSTN)
      wdog_hit |=> irq_st_r[CSCR_WDOG_BIT] && wdog_cnt_r == '0)
      else $error("watchdog timeout not flagged");

   // Self-test starts, self-test and version read-back, and idle read data.
   integ_start_a: assert property (@(posedge CLK) disable iff (!RSTN)
      (wr_test && BUS.wdata[CSCR_PRBS_BIT]) |=> LINK_INTEGRITY_TEST_GO)
      else $error("integrity test not started");
   slow_pulse_a: assert property (@(posedge CLK) disable iff (!RSTN)
      SLOW_BUS_TEST_GO |=> !SLOW_BUS_TEST_GO || $past(wr_test))
      else $error("slow bus start not a pulse");
   test_read_a: assert property (@(posedge CLK) disable iff (!RSTN)
      (BUS.rd && hit(BUS, CSCR_SELF_TEST_ADR)) |=> RDATA == '0)
      else $error("self-test bits read nonzero");
   version_read_a: assert property (@(posedge CLK) disable iff (!RSTN)
      (BUS.rd && hit(BUS, CSCR_VERSION_ADR)) |=>
         RDATA == {BUILD_LEVEL, MINOR_VERSION, MAJOR_VERSION, BUILD_NUMBER})
      else $error("version word wrong");
   rdata_idle_a: assert property (@(posedge CLK) disable iff (!RSTN)
      !BUS.rd |=> RDATA == '0)
      else $error("read data outside read cycle");

   // Output copies of control bits must never drift from the registers; the sync latch rearms on release.
   wden_mirror_a: assert property (@(posedge CLK) disable iff (!RSTN)
      WATCHDOG_EN == wden_r)
      else $error("watchdog enable output drifted");
   latch_mirror_a: assert property (@(posedge CLK) disable iff (!RSTN)
      SYNC_ERR_LATCH_RESET == latch_rst_r)
      else $error("latch reset output drifted");
   sync_rearm_a: assert property (@(posedge CLK) disable iff (!RSTN)
      release_s ##1 syncerr_s |=> sync_flag_r)
      else $error("sync latch not rearmed");

   // Interrupt status clearing and watchdog idling.
   irq_clear_a: assert property (@(posedge CLK) disable iff (!RSTN)
      !(|(irq_st_r & irq_en_r)) |=> !IRQ)
      else $error("interrupt stuck after clear");
   herr_clear_a: assert property (@(posedge CLK) disable iff (!RSTN)
      (wr_irq_st && BUS.wdata[CSCR_HERR_LO] && !herr_s[0]) |=> !irq_st_r[CSCR_HERR_LO])
      else $error("hard error not cleared");
   wdog_idle_a: assert property (@(posedge CLK) disable iff (!RSTN)
      !wden_r |=> wdog_cnt_r == '0)
      else $error("watchdog counts while disabled");
endmodule

// File: sim/cscr_far_model.sv
/*
 * Far-side model for the register bank: status sources, channel errors,
 * interface sync errors and block resets, plus counters of test starts.
 * Assumes the bench sets the request inputs just after a rising edge.
 */
`timescale 1ns/10ps
module cscr_far_model (
   input wire logic clk,             // Controller clock
   input wire logic rstn,            // Sync reset, low
   input wire logic [3:0] stat_req,  // Wanted status levels
   input wire logic [3:0] herr_req,  // Wanted hard errors
   input wire logic sync_req,        // Wanted sync error
   input wire logic blk_req,         // Wanted block reset
   input wire logic integ_go,        // Integrity test start
   input wire logic slow_go,         // Slow bus test start
   output logic [3:0] stat,          // PLL, supply, parked, fast power
   output logic [3:0] hard_err,      // Channel hard errors
   output logic sync_err,            // Interface sync error
   output logic blk_reset,           // Block reset event
   output logic [7:0] integ_cnt,     // Integrity starts seen
   output logic [7:0] slow_cnt       // Slow bus starts seen
);
   always_ff @(posedge clk) begin
      stat <= stat_req;
      hard_err <= herr_req;
      sync_err <= sync_req;
      blk_reset <= blk_req;
   end
   ////////////////////////////////////////////////////////////////////////
   // A start that stays high for two cycles counts twice, so a stuck trigger shows.
   always_ff @(posedge clk) begin
      if (!rstn) begin
         integ_cnt <= 8'h00;
         slow_cnt <= 8'h00;
      end else begin
         integ_cnt <= integ_cnt + {7'h00, integ_go};
         slow_cnt <= slow_cnt + {7'h00, slow_go};
      end
   end
endmodule

// File: sim/tb.sv
/*
 * Self-checking bench for the register bank.
 * Assumes the one-cycle strobe bus and a shortened watchdog count.
 */
`timescale 1ns/10ps
module tb;
   import cscr_pkg::*;
   logic CLK = 1'b0, RSTN = 1'b0, IRQ, WDEN, IGO, SGO, LRST, sync_req = 1'b0, blk_req = 1'b1;
   logic [3:0] stat_req = 4'h0, herr_req = 4'h0, stat, herr;
   logic sync_err, blk_reset;
   logic [7:0] icnt, scnt;
   logic [31:0] RDATA;
   cscr_bus_s bus = '0;
   int bad_count = 0, checks = 0;
   cscr_regs #(.BUILD_NUMBER(12'hABC), .MAJOR_VERSION(8'h5A), .MINOR_VERSION(8'hC3),
      .BUILD_LEVEL(4'h0), .WDOG_CYCLES(50)) i_cscr_regs (.CLK(CLK), .RSTN(RSTN), .BUS(bus),
      .RDATA(RDATA), .HARD_ERR(herr), .PLL_LOCK(stat[0]), .ARRAY_SUPPLY_GOOD(stat[1]),
      .ARRAY_PARKED(stat[2]), .FAST_IF_POWER_ON(stat[3]), .ARRAY_BLOCK_RESET(blk_reset),
      .SYNC_ERR(sync_err), .IRQ(IRQ), .WATCHDOG_EN(WDEN), .LINK_INTEGRITY_TEST_GO(IGO),
      .SLOW_BUS_TEST_GO(SGO), .SYNC_ERR_LATCH_RESET(LRST));
   cscr_far_model i_cscr_far_model (.clk(CLK), .rstn(RSTN), .stat_req(stat_req),
      .herr_req(herr_req), .sync_req(sync_req), .blk_req(blk_req), .integ_go(IGO),
      .slow_go(SGO), .stat(stat), .hard_err(herr), .sync_err(sync_err),
      .blk_reset(blk_reset), .integ_cnt(icnt), .slow_cnt(scnt));
   initial begin
      forever #5 CLK = ~CLK;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, exp, input string m);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge CLK);
   endtask
   // Every access ends one edge after the strobe, so strobes never meet.
   task automatic acc(input logic w, input logic [31:0] a, d, output logic [31:0] q);
      bus <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge CLK);
      bus <= '0;
      #1 q = RDATA;
      @(posedge CLK);
   endtask
   task automatic wr(input logic [31:0] a, d);
      logic [31:0] q;
      acc(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [31:0] a, exp, input string m);
      logic [31:0] q;
      acc(1'b0, a, 32'h0000_0000, q);
      chk(q, exp, m);
   endtask
   task automatic end_of_test();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rdc(CSCR_IRQ_ENABLE_ADR, 32'h0000_0000, "enable reset");
      rdc(CSCR_MAIN_CTRL_ADR, 32'h0000_0001, "ctrl reset");
      chk({31'h0, WDEN}, 32'h0000_0001, "wdog out reset");
      rdc(CSCR_SYNC_CLR_ADR, 32'h0000_0000, "latch reset");
      rdc(CSCR_MAIN_STATUS_ADR, 32'h0000_0000, "status reset");
      wr(32'h4000_0018, 32'hFFFF_FFFF);
      rdc(32'h4000_0018, 32'h0000_0000, "unmapped");
      $display("test reset done");
   endtask
   task automatic t_status();
      for (int i = 0; i < 4; i++) begin
         stat_req <= 4'(1 << i);
         cyc(5);
         rdc(CSCR_MAIN_STATUS_ADR, 32'(1 << i), "status bit");
      end
      stat_req <= 4'hF;
      cyc(5);
      wr(CSCR_MAIN_STATUS_ADR, 32'h0000_0000);
      rdc(CSCR_MAIN_STATUS_ADR, 32'h0000_000F, "status ro");
      wr(CSCR_VERSION_ADR, 32'hFFFF_FFFF);
      rdc(CSCR_VERSION_ADR, 32'h0C35_AABC, "version");
      wr(CSCR_MAIN_CTRL_ADR, 32'h0000_0000);
      chk({31'h0, WDEN}, 32'h0000_0000, "wdog off");
      wr(CSCR_MAIN_CTRL_ADR, 32'hFFFF_FFFF);
      rdc(CSCR_MAIN_CTRL_ADR, 32'h0000_0001, "ctrl spare");
      $display("test status done");
   endtask
   task automatic t_selftest();
      wr(CSCR_SELF_TEST_ADR, 32'h0000_0001);
      cyc(1);
      chk({16'h0, icnt, scnt}, 32'h0000_0100, "integrity go");
      wr(CSCR_SELF_TEST_ADR, 32'h0000_0002);
      wr(CSCR_SELF_TEST_ADR, 32'h0000_0003);
      cyc(2);
      chk({16'h0, icnt, scnt}, 32'h0000_0202, "slow bus go");
      rdc(CSCR_SELF_TEST_ADR, 32'h0000_0000, "self test reads");
      $display("test selftest done");
   endtask
   task automatic t_irq();
      for (int i = 0; i < 4; i++) begin
         herr_req <= 4'(1 << i);
         cyc(6);
         chk({31'h0, IRQ}, 32'h0000_0000, "irq masked");
         rdc(CSCR_IRQ_STATUS_ADR, 32'(8 << i), "hard err set");
         wr(CSCR_IRQ_ENABLE_ADR, 32'(8 << i));
         cyc(1);
         chk({31'h0, IRQ}, 32'h0000_0001, "irq on");
         herr_req <= 4'h0;
         cyc(5);
         wr(CSCR_IRQ_STATUS_ADR, 32'(8 << i));
         cyc(1);
         chk({31'h0, IRQ}, 32'h0000_0000, "irq off");
         rdc(CSCR_IRQ_STATUS_ADR, 32'h0000_0000, "hard err clear");
         wr(CSCR_IRQ_ENABLE_ADR, 32'h0000_0000);
      end
      $display("test irq done");
   endtask
   task automatic t_sync();
      sync_req <= 1'b1;
      cyc(3);
      sync_req <= 1'b0;
      cyc(5);
      rdc(CSCR_SYNC_STATUS_ADR, 32'h0000_0001, "sync set");
      wr(CSCR_SYNC_STATUS_ADR, 32'hFFFF_FFFF);
      wr(CSCR_SYNC_STATUS_ADR, 32'h0000_0000);
      rdc(CSCR_SYNC_STATUS_ADR, 32'h0000_0001, "sync sticky");
      wr(CSCR_SYNC_CLR_ADR, 32'hFFFF_FFFF);
      chk({31'h0, LRST}, 32'h0000_0001, "latch out");
      rdc(CSCR_SYNC_CLR_ADR, 32'h0000_0001, "latch bits");
      sync_req <= 1'b1;
      cyc(50);
      rdc(CSCR_SYNC_STATUS_ADR, 32'h0000_0000, "held clear");
      sync_req <= 1'b0;
      cyc(5);
      wr(CSCR_SYNC_CLR_ADR, 32'h0000_0000);
      rdc(CSCR_SYNC_STATUS_ADR, 32'h0000_0000, "released");
      sync_req <= 1'b1;
      cyc(3);
      sync_req <= 1'b0;
      cyc(5);
      rdc(CSCR_SYNC_STATUS_ADR, 32'h0000_0001, "rearmed");
      $display("test sync done");
   endtask
   task automatic t_wdog();
      wr(CSCR_IRQ_STATUS_ADR, 32'h0000_0004);
      cyc(60);
      rdc(CSCR_IRQ_STATUS_ADR, 32'h0000_0000, "wdog fed");
      blk_req <= 1'b0;
      cyc(60);
      rdc(CSCR_IRQ_STATUS_ADR, 32'h0000_0004, "wdog timeout");
      wr(CSCR_IRQ_ENABLE_ADR, 32'h0000_0004);
      cyc(1);
      chk({31'h0, IRQ}, 32'h0000_0001, "wdog irq");
      wr(CSCR_MAIN_CTRL_ADR, 32'h0000_0000);
      wr(CSCR_IRQ_STATUS_ADR, 32'h0000_0004);
      cyc(60);
      chk({31'h0, IRQ}, 32'h0000_0000, "wdog irq off");
      rdc(CSCR_IRQ_STATUS_ADR, 32'h0000_0000, "wdog disabled");
      $display("test watchdog done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(2);
      RSTN <= 1'b1;
      cyc(1);
      t_reset();
      t_status();
      t_selftest();
      t_irq();
      t_sync();
      t_wdog();
      end_of_test();
   end
   // The whole run takes well under a thousand cycles.
   initial begin
      #50us;
      bad_count++;
      end_of_test();
   end
endmodule
